// *** rtl/spl_action_decode.sv ***
// decodes an 8-bit action setting into one-hot action strobes and a motor mask
`timescale 1ns/1ns
module spl_action_decode (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    spl_action_if.dst       req,
    output logic [8:1]      action_out,
    output logic [3:1]      motor_out
);
    wire [3:0] code_w  = req.setting[spl_pkg::CODE_LSB +: spl_pkg::CODE_W];
    wire [3:0] motor_w = req.setting[spl_pkg::MOTOR_LSB +: spl_pkg::MOTOR_W];
    wire       act_ok_w = req.fire && code_w != spl_pkg::ACT_NONE
                          && code_w <= spl_pkg::ACT_LOAD_HOME; // RULE5
    logic [8:1] act_d;
    logic [3:1] mot_d;

    always_comb begin
        act_d = 8'h00;
        if (act_ok_w) begin
            act_d[code_w] = 1'b1; // RULE5
        end
    end

    // motor field: 16, 32, 48 select motor one, two, three; only with a real action
    assign mot_d = act_ok_w ? {motor_w == spl_pkg::MOTOR_THREE,
                               motor_w == spl_pkg::MOTOR_TWO,
                               motor_w == spl_pkg::MOTOR_ONE} : 3'h0; // RULE6

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            action_out <= 8'h00;
            motor_out  <= 3'h0;
        end else begin
            action_out <= act_d;
            motor_out  <= mot_d;
        end
    end
endmodule : spl_action_decode

// *** rtl/spl_action_if.sv ***
// action request passed from the limit compare to the action decoder
`timescale 1ns/1ns
interface spl_action_if;
    logic        fire;
    logic [7:0]  setting;
    modport src (output fire, output setting);
    modport dst (input  fire, input  setting);
endinterface : spl_action_if

// *** rtl/spl_pkg.sv ***
// constants and types shared by the sensor position limit logic
package spl_pkg;
    localparam int           CNT_W            = 32;
    localparam int           CMD_W            = 16;
    localparam int           ACT_W            = 8;
    localparam int           CODE_LSB         = 0;
    localparam int           CODE_W           = 4;
    localparam int           MOTOR_LSB        = 4;
    localparam int           MOTOR_W          = 4;
    localparam logic [31:0]  HOME_RST         = 32'h0000_0000;
    localparam logic [31:0]  LOW_LIMIT_RST    = 32'hffff_b1e0;
    localparam logic [31:0]  HIGH_LIMIT_RST   = 32'h0000_4e20;
    localparam logic [7:0]   ACTION_RST       = 8'h00;
    localparam logic [7:0]   USAGE_RST        = 8'h00;
    localparam logic [15:0]  CMD_MIN          = 16'hfc18;
    localparam logic [15:0]  CMD_MAX          = 16'h03e8;
    localparam logic [15:0]  CMD_SPAN         = 16'h07d0;
    localparam logic [3:0]   MOTOR_ONE        = 4'h1;
    localparam logic [3:0]   MOTOR_TWO        = 4'h2;
    localparam logic [3:0]   MOTOR_THREE      = 4'h3;

    typedef enum logic [3:0] {
        ACT_NONE        = 4'h0,
        ACT_SAFETY_STOP = 4'h1,
        ACT_EMERG_STOP  = 4'h2,
        ACT_MOTOR_STOP  = 4'h3,
        ACT_FWD_LIMIT   = 4'h4,
        ACT_REV_LIMIT   = 4'h5,
        ACT_INVERT_DIR  = 4'h6,
        ACT_RUN_SCRIPT  = 4'h7,
        ACT_LOAD_HOME   = 4'h8
    } spl_action_t;

    typedef enum logic [3:0] {
        USE_UNUSED   = 4'h0,
        USE_COMMAND  = 4'h1,
        USE_FEEDBACK = 4'h2,
        USE_ABSOLUTE = 4'h3
    } spl_usage_t;
endpackage : spl_pkg

// *** rtl/spl_position_limits.sv ***
// sensor position counter with home load, offset, soft limits and relative targets
`timescale 1ns/1ns
// Summary of operation
// RULE1: a home switch, host home command or script home command loads the counter with the home value; the code ignores all three in absolute feedback usage.
// RULE2: in absolute feedback usage the home value is subtracted from the raw count as an offset.
// RULE3: a counter below the low limit (default -20000) fires the low-limit action.
// RULE4: a relative command of -1000 targets the low-limit count.
// RULE5: action code 0 is no action and 1 to 8 select the eight documented actions.
// RULE6: the upper part of an action setting selects motor one, two or three by 16, 32, 48.
// RULE7: usage code 0 unused, 1 command, 2 feedback, 3 absolute feedback, with the motor above.
// RULE8: absolute feedback usage feeds the offset absolute count to position control.
// RULE9: a counter above the high limit (default +20000) fires the high-limit action.
// RULE10: a relative command of +1000 targets the high-limit count.
// RULE11: commands between the extremes map linearly between the limits with wide signed math.
module spl_position_limits (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        HOME_SWITCH_IN,
    input  wire logic        HOST_HOME_CMD_IN,
    input  wire logic        SCRIPT_HOME_CMD_IN,
    input  wire logic        RAW_VALID_IN,
    input  wire logic [31:0] RAW_COUNT_IN,
    input  wire logic [31:0] SENSOR_HOME_VALUE_IN,
    input  wire logic [31:0] SENSOR_LOW_LIMIT_IN,
    input  wire logic [31:0] SENSOR_HIGH_LIMIT_IN,
    input  wire logic [7:0]  SENSOR_LOW_LIMIT_ACTION_IN,
    input  wire logic [7:0]  SENSOR_HIGH_LIMIT_ACTION_IN,
    input  wire logic [7:0]  SENSOR_USAGE_SELECT_IN,
    input  wire logic        REL_CMD_VALID_IN,
    input  wire logic [15:0] REL_CMD_IN,
    output logic [31:0]      COUNT_OUT,
    output logic             LOW_LIMIT_OUT,
    output logic             HIGH_LIMIT_OUT,
    output logic [8:1]       LOW_ACTION_OUT,
    output logic [3:1]       LOW_MOTOR_OUT,
    output logic [8:1]       HIGH_ACTION_OUT,
    output logic [3:1]       HIGH_MOTOR_OUT,
    output logic [1:0]       USAGE_OUT,
    output logic [3:1]       USAGE_MOTOR_OUT,
    output logic             FEEDBACK_VALID_OUT,
    output logic [31:0]      FEEDBACK_OUT,
    output logic             COMMAND_VALID_OUT,
    output logic [31:0]      COMMAND_OUT,
    output logic             TARGET_VALID_OUT,
    output logic [31:0]      TARGET_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers for the home switch

    logic       home_meta_q;
    logic       home_sync_q;
    logic       home_prev_q;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            home_meta_q <= 1'b0;
            home_sync_q <= 1'b0;
            home_prev_q <= 1'b0;
        end else begin
            home_meta_q <= HOME_SWITCH_IN;
            home_sync_q <= home_meta_q;
            home_prev_q <= home_sync_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // usage decode

    wire [3:0] use_code_w  = SENSOR_USAGE_SELECT_IN[spl_pkg::CODE_LSB +: spl_pkg::CODE_W];
    wire [3:0] use_motor_w = SENSOR_USAGE_SELECT_IN[spl_pkg::MOTOR_LSB +: spl_pkg::MOTOR_W];
    wire       use_cmd_w   = use_code_w == spl_pkg::USE_COMMAND;  // RULE7
    wire       use_fb_w    = use_code_w == spl_pkg::USE_FEEDBACK; // RULE7
    wire       use_abs_w   = use_code_w == spl_pkg::USE_ABSOLUTE; // RULE7

    ////////////////////////////////////////////////////////////////////////////////
    // counter: home load or offset subtraction

    logic [31:0] count_q;
    logic [31:0] count_d;
    logic        lim_hit_low_q;
    logic        lim_hit_high_q;

    wire home_evt_w = (home_sync_q && !home_prev_q) || HOST_HOME_CMD_IN || SCRIPT_HOME_CMD_IN;
    wire low_load_w  = lim_hit_low_q && LOW_ACTION_OUT[spl_pkg::ACT_LOAD_HOME];
    wire high_load_w = lim_hit_high_q && HIGH_ACTION_OUT[spl_pkg::ACT_LOAD_HOME];
    wire [31:0] abs_count_w = RAW_COUNT_IN - SENSOR_HOME_VALUE_IN; // RULE2

    always_comb begin
        count_d = count_q;
        if (use_abs_w) begin
            if (RAW_VALID_IN) begin
                count_d = abs_count_w; // RULE2
            end
        end else if (home_evt_w || low_load_w || high_load_w) begin
            count_d = SENSOR_HOME_VALUE_IN; // RULE1
        end else if (RAW_VALID_IN) begin
            count_d = RAW_COUNT_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // limit compare

    wire below_w = $signed(count_q) < $signed(SENSOR_LOW_LIMIT_IN);  // RULE3
    wire above_w = $signed(count_q) > $signed(SENSOR_HIGH_LIMIT_IN); // RULE9

    // action fires on entry into the limit region
    spl_action_if low_req ();
    spl_action_if high_req ();
    assign low_req.fire     = below_w && !lim_hit_low_q;  // RULE3
    assign low_req.setting  = SENSOR_LOW_LIMIT_ACTION_IN;
    assign high_req.fire    = above_w && !lim_hit_high_q; // RULE9
    assign high_req.setting = SENSOR_HIGH_LIMIT_ACTION_IN;

    spl_action_decode u_low_dec (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (RST_IN),
        .req        (low_req),
        .action_out (LOW_ACTION_OUT),
        .motor_out  (LOW_MOTOR_OUT)
    );

    spl_action_decode u_high_dec (
        .clk_in     (SYS_CLK_IN),
        .rst_in     (RST_IN),
        .req        (high_req),
        .action_out (HIGH_ACTION_OUT),
        .motor_out  (HIGH_MOTOR_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // relative command to target

    function automatic logic [31:0] rel_target(input logic [15:0] cmd,
                                               input logic [31:0] lo,
                                               input logic [31:0] hi);
        logic signed [51:0] span;
        logic signed [51:0] ofs;
        logic signed [51:0] prod;
        logic signed [51:0] quot;
        // command offset from the low end, widened signed before the add
        span = $signed({{20{hi[31]}}, hi}) - $signed({{20{lo[31]}}, lo});
        ofs  = $signed({{36{cmd[15]}}, cmd}) + $signed({36'h0, spl_pkg::CMD_MAX});
        prod = span * ofs;
        quot = prod / $signed({36'h0, spl_pkg::CMD_SPAN});
        rel_target = lo + quot[31:0];
    endfunction : rel_target

    logic [31:0] target_d;
    always_comb begin
        if (REL_CMD_IN == spl_pkg::CMD_MIN) begin
            target_d = SENSOR_LOW_LIMIT_IN;  // RULE4
        end else if (REL_CMD_IN == spl_pkg::CMD_MAX) begin
            target_d = SENSOR_HIGH_LIMIT_IN; // RULE10
        end else begin
            target_d = rel_target(REL_CMD_IN, SENSOR_LOW_LIMIT_IN, SENSOR_HIGH_LIMIT_IN); // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter and limit flags

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            count_q        <= spl_pkg::HOME_RST;
            lim_hit_low_q  <= 1'b0;
            lim_hit_high_q <= 1'b0;
        end else begin
            count_q        <= count_d;
            lim_hit_low_q  <= below_w;
            lim_hit_high_q <= above_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // feedback and command outputs

    wire fb_take_w  = (use_fb_w || use_abs_w) && RAW_VALID_IN; // RULE8
    wire cmd_take_w = use_cmd_w && RAW_VALID_IN;                // RULE7

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            FEEDBACK_VALID_OUT <= 1'b0;
            FEEDBACK_OUT       <= 32'h0000_0000;
            COMMAND_VALID_OUT  <= 1'b0;
            COMMAND_OUT        <= 32'h0000_0000;
        end else begin
            FEEDBACK_VALID_OUT <= fb_take_w;
            COMMAND_VALID_OUT  <= cmd_take_w;
            if (fb_take_w) begin
                FEEDBACK_OUT <= count_d; // RULE8
            end
            if (cmd_take_w) begin
                COMMAND_OUT <= count_d;  // RULE7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // target output

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            TARGET_VALID_OUT <= 1'b0;
            TARGET_OUT       <= 32'h0000_0000;
        end else begin
            TARGET_VALID_OUT <= REL_CMD_VALID_IN;
            if (REL_CMD_VALID_IN) begin
                TARGET_OUT <= target_d; // RULE11
            end
        end
    end

    assign COUNT_OUT       = count_q;
    assign LOW_LIMIT_OUT   = lim_hit_low_q;
    assign HIGH_LIMIT_OUT  = lim_hit_high_q;
    assign USAGE_OUT       = use_code_w <= spl_pkg::USE_ABSOLUTE ? use_code_w[1:0] : 2'h0;
    assign USAGE_MOTOR_OUT = {use_motor_w == spl_pkg::MOTOR_THREE,
                              use_motor_w == spl_pkg::MOTOR_TWO,
                              use_motor_w == spl_pkg::MOTOR_ONE}; // RULE7

endmodule : spl_position_limits

// *** verif/spl_position_limits_checker.sv ***
// port assertions for the sensor position limit block
`timescale 1ns/1ns
module spl_chk (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_IN,
    input wire logic        HOST_HOME_CMD_IN,
    input wire logic        RAW_VALID_IN,
    input wire logic [31:0] RAW_COUNT_IN,
    input wire logic [31:0] SENSOR_HOME_VALUE_IN,
    input wire logic [31:0] SENSOR_LOW_LIMIT_IN,
    input wire logic [31:0] SENSOR_HIGH_LIMIT_IN,
    input wire logic [7:0]  SENSOR_LOW_LIMIT_ACTION_IN,
    input wire logic [7:0]  SENSOR_USAGE_SELECT_IN,
    input wire logic        REL_CMD_VALID_IN,
    input wire logic [15:0] REL_CMD_IN,
    input wire logic [31:0] COUNT_OUT,
    input wire logic        LOW_LIMIT_OUT,
    input wire logic        HIGH_LIMIT_OUT,
    input wire logic [8:1]  LOW_ACTION_OUT,
    input wire logic [3:1]  LOW_MOTOR_OUT,
    input wire logic [1:0]  USAGE_OUT,
    input wire logic [3:1]  USAGE_MOTOR_OUT,
    input wire logic        FEEDBACK_VALID_OUT,
    input wire logic [31:0] FEEDBACK_OUT,
    input wire logic        COMMAND_VALID_OUT,
    input wire logic [31:0] COMMAND_OUT,
    input wire logic        TARGET_VALID_OUT,
    input wire logic [31:0] TARGET_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    wire [3:0] use_w  = SENSOR_USAGE_SELECT_IN[3:0];
    wire [3:0] code_w = SENSOR_LOW_LIMIT_ACTION_IN[3:0];
    wire [3:0] mot_w  = SENSOR_LOW_LIMIT_ACTION_IN[7:4];
    wire [3:0] umot_w = SENSOR_USAGE_SELECT_IN[7:4];
    sequence s_enter; $rose(LOW_LIMIT_OUT) && code_w inside {[1:8]} && mot_w inside {[1:3]}; endsequence
    sequence s_tmin; REL_CMD_VALID_IN && REL_CMD_IN == spl_pkg::CMD_MIN; endsequence
    property p_home; HOST_HOME_CMD_IN && use_w != 4'h3 |=> COUNT_OUT == $past(SENSOR_HOME_VALUE_IN); endproperty
    property p_abs; RAW_VALID_IN && use_w == 4'h3 |=>
        COUNT_OUT == $past(RAW_COUNT_IN) - $past(SENSOR_HOME_VALUE_IN); endproperty
    property p_low; 1'b1 |=>
        LOW_LIMIT_OUT == ($signed($past(COUNT_OUT)) < $signed($past(SENSOR_LOW_LIMIT_IN))); endproperty
    property p_act; s_enter |->
        LOW_ACTION_OUT == 8'(1 << (code_w - 1)) && LOW_MOTOR_OUT == 3'(1 << (mot_w - 1)); endproperty
    property p_once; LOW_ACTION_OUT != 8'h0 |-> $rose(LOW_LIMIT_OUT); endproperty
    property p_tmin; s_tmin |=> TARGET_VALID_OUT && TARGET_OUT == $past(SENSOR_LOW_LIMIT_IN); endproperty
    property p_tmax; REL_CMD_VALID_IN && REL_CMD_IN == spl_pkg::CMD_MAX |=>
        TARGET_VALID_OUT && TARGET_OUT == $past(SENSOR_HIGH_LIMIT_IN); endproperty
    property p_use; USAGE_OUT == (use_w <= 4'h3 ? use_w[1:0] : 2'h0); endproperty
    property p_high; 1'b1 |=>
        HIGH_LIMIT_OUT == ($signed($past(COUNT_OUT)) > $signed($past(SENSOR_HIGH_LIMIT_IN)));
    endproperty
    property p_fb; RAW_VALID_IN && use_w inside {4'h2, 4'h3} |=>
        FEEDBACK_VALID_OUT && FEEDBACK_OUT == COUNT_OUT; endproperty
    property p_cmd; RAW_VALID_IN && use_w == 4'h1 |=>
        COMMAND_VALID_OUT && COMMAND_OUT == COUNT_OUT; endproperty
    property p_umot;
        USAGE_MOTOR_OUT == (umot_w inside {[1:3]} ? 3'(1 << (umot_w - 1)) : 3'h0); endproperty
    a_home: assert property (p_home) else $error("home load wrong");
    a_abs: assert property (p_abs) else $error("offset count wrong");
    a_low: assert property (p_low) else $error("low limit flag wrong");
    a_act: assert property (p_act) else $error("low action decode wrong");
    a_once: assert property (p_once) else $error("action without entry");
    a_tmin: assert property (p_tmin) else $error("low target wrong");
    a_tmax: assert property (p_tmax) else $error("high target wrong");
    a_use: assert property (p_use) else $error("usage decode wrong");
    a_high: assert property (p_high) else $error("high limit flag wrong");
    a_fb: assert property (p_fb) else $error("feedback output wrong");
    a_cmd: assert property (p_cmd) else $error("command output wrong");
    a_umot: assert property (p_umot) else $error("usage motor decode wrong");
endmodule : spl_chk
bind spl_position_limits spl_chk u_chk (.SYS_CLK_IN, .RST_IN, .HOST_HOME_CMD_IN, .RAW_VALID_IN,
    .RAW_COUNT_IN, .SENSOR_HOME_VALUE_IN, .SENSOR_LOW_LIMIT_IN, .SENSOR_HIGH_LIMIT_IN,
    .SENSOR_LOW_LIMIT_ACTION_IN, .SENSOR_USAGE_SELECT_IN, .REL_CMD_VALID_IN, .REL_CMD_IN,
    .COUNT_OUT, .LOW_LIMIT_OUT, .HIGH_LIMIT_OUT, .LOW_ACTION_OUT, .LOW_MOTOR_OUT, .USAGE_OUT,
    .USAGE_MOTOR_OUT, .FEEDBACK_VALID_OUT, .FEEDBACK_OUT, .COMMAND_VALID_OUT, .COMMAND_OUT,
    .TARGET_VALID_OUT, .TARGET_OUT);

// *** verif/spl_sensor_model.sv ***
// behavioural absolute position sensor delivering one count per request
`timescale 1ns/1ns
module spl_sensor_model (
    input  wire logic   clk_in,
    output logic        valid_out,
    output logic [31:0] count_out
);
    initial {valid_out, count_out} = 33'h0;
    // slow answers wait whole periods; back-to-back counts keep valid high
    task automatic send(input logic [31:0] v, input int lat);
        repeat (lat) begin
            {valid_out, count_out} = {1'b0, ~v};
            @(posedge clk_in) #1;
        end
        {valid_out, count_out} = {1'b1, v};
        @(posedge clk_in) #1;
    endtask : send
    // release after the last count; idle data shows the inverse, never a stale count
    task automatic idle();
        {valid_out, count_out} = {1'b0, ~count_out};
    endtask : idle
endmodule : spl_sensor_model

// *** verif/tb_top.sv ***
// self-checking bench for the sensor position limit block
`timescale 1ns/1ns
module tb_top;
    logic        clk = 1'b0, rst = 1'b1, hsw = 1'b0, hh = 1'b0, sh = 1'b0, cv = 1'b0;
    logic [31:0] home = 32'h0, lo = spl_pkg::LOW_LIMIT_RST, hi = spl_pkg::HIGH_LIMIT_RST;
    logic [7:0]  la = 8'h0, ha = 8'h0, us = 8'h0;
    logic [15:0] cmd = 16'h0;
    logic [31:0] cnt, fb, tg, cm, raw, c, q_fb[$], q_tg[$], q_act[$], q_cm[$];
    logic [8:1]  lact, hact;
    logic [3:1]  lmot, hmot;
    logic        rv, fbv, tgv, cmv;
    int          err_count = 0, num_checks = 0, m;
    longint      e;
    always #2 clk = ~clk;
    spl_sensor_model sen (.clk_in(clk), .valid_out(rv), .count_out(raw));
    spl_position_limits dut (.SYS_CLK_IN(clk), .RST_IN(rst), .HOME_SWITCH_IN(hsw),
        .HOST_HOME_CMD_IN(hh), .SCRIPT_HOME_CMD_IN(sh), .RAW_VALID_IN(rv), .RAW_COUNT_IN(raw),
        .SENSOR_HOME_VALUE_IN(home), .SENSOR_LOW_LIMIT_IN(lo), .SENSOR_HIGH_LIMIT_IN(hi),
        .SENSOR_LOW_LIMIT_ACTION_IN(la), .SENSOR_HIGH_LIMIT_ACTION_IN(ha),
        .SENSOR_USAGE_SELECT_IN(us), .REL_CMD_VALID_IN(cv), .REL_CMD_IN(cmd), .COUNT_OUT(cnt),
        .LOW_LIMIT_OUT(), .HIGH_LIMIT_OUT(), .LOW_ACTION_OUT(lact), .LOW_MOTOR_OUT(lmot),
        .HIGH_ACTION_OUT(hact), .HIGH_MOTOR_OUT(hmot), .USAGE_OUT(), .USAGE_MOTOR_OUT(),
        .FEEDBACK_VALID_OUT(fbv), .FEEDBACK_OUT(fb), .COMMAND_VALID_OUT(cmv), .COMMAND_OUT(cm),
        .TARGET_VALID_OUT(tgv), .TARGET_OUT(tg));
    function automatic logic [31:0] nx(ref logic [31:0] q[$]);
        return q.size() ? q.pop_front() : 'x;
    endfunction : nx
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, x, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk) #1;
    endtask : tick
    task automatic put(input logic [31:0] v, input int lat);
        if (us[3:0] == 4'h3) q_fb.push_back(v - home);
        else if (us[3:0] == 4'h2) q_fb.push_back(v);
        else if (us[3:0] == 4'h1) q_cm.push_back(v);
        sen.send(v, lat);
    endtask : put
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    always @(negedge clk) begin
        if (fbv === 1'b1) chk("feedback", nx(q_fb), fb);
        if (tgv === 1'b1) chk("target", nx(q_tg), tg);
        if (cmv === 1'b1) chk("command", nx(q_cm), cm);
        if (|{lact, lmot}) chk("low action", nx(q_act), {20'h0, 1'b0, lmot, lact});
        if (|{hact, hmot}) chk("high action", nx(q_act), {20'h0, 1'b1, hmot, hact});
    end
    initial begin
        void'($urandom(81270));
        tick(2);
        rst = 1'b0;
        for (int u = 0; u < 6; u++) begin
            us = 8'(u + 48);
            tick(1);
        end
        us = 8'h13;
        home = 32'd10;
        put(32'd100, 0);
        for (int i = 0; i < 4; i++) begin
            home = $urandom_range(10000) - 5000;
            c = $urandom_range(20000) - 10000;
            put(c, i);
        end
        sen.idle();
        hh = 1'b1;
        tick(1);
        hh = 1'b0;
        tick(1);
        chk("absolute home", c - home, cnt);
        us = 8'h11;
        put($urandom_range(20000), 0);
        sen.idle();
        us = 8'h22;
        for (int k = 0; k < 3; k++) begin
            home = $urandom_range(10000);
            {hsw, sh, hh} = 3'(1 << k);
            tick(1);
            {sh, hh} = 2'h0;
            tick(4);
            hsw = 1'b0;
            chk("home load", home, cnt);
        end
        home = 32'h0;
        for (int s = 0; s < 2; s++)
            for (int a = 0; a < 9; a++) begin
                m = a % 3 + 1;
                {ha, la} = s ? {8'(m * 16 + a), 8'h0} : {8'h0, 8'(m * 16 + a)};
                put(s ? 32'd20000 : -32'sd20000, 0);
                put(s ? 32'd20001 : -32'sd20001, 0);
                sen.idle();
                if (a > 0) q_act.push_back({s[0], 3'(1 << (m - 1)), 8'(1 << (a - 1))});
                tick(3);
                put(32'h0, 1);
                sen.idle();
                tick(3);
            end
        {la, ha} = 16'h0;
        cv = 1'b1;
        for (int i = 0; i < 12; i++) begin
            lo = -$urandom_range(100000);
            hi = $urandom_range(100000);
            cmd = i < 2 ? (i ? spl_pkg::CMD_MAX : spl_pkg::CMD_MIN) : 16'($urandom_range(2000) - 1000);
            e = longint'($signed(hi)) - $signed(lo);
            e = longint'($signed(lo)) + e * (longint'($signed(cmd)) + 1000) / 2000;
            q_tg.push_back(32'(e));
            tick(1);
        end
        cv = 1'b0;
        tick(5);
        chk("left over", 32'h0, 32'(q_fb.size() + q_tg.size() + q_act.size() + q_cm.size()));
        test_done();
    end
    initial begin
        // sequence needs well under a thousand cycles
        #100000;
        err_count++;
        test_done();
    end
endmodule : tb_top
